// >>> common/tgc_pkg.sv
// Constants and types shared by the three-phase gate control block
package tgc_pkg;
    localparam int NUM_PHASES = 3;
    // Avalon-MM register map (byte addresses)
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_CONFIG = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h8;
    // Control register fields
    localparam int CTRL_HIGH_LSB = 0;
    localparam int CTRL_LOW_LSB = 3;
    localparam logic [5:0] CTRL_RESET = 6'h00;
    // Configuration register fields
    localparam int CFG_MODE_BIT = 0;
    // Status register fields
    localparam int STAT_INT_HIGH_LSB = 0;
    localparam int STAT_INT_LOW_LSB = 3;
    localparam int STAT_GATE_HIGH_LSB = 6;
    localparam int STAT_GATE_LOW_LSB = 9;
    localparam int STAT_ACTIVE_BIT = 12;
    localparam int STAT_TIMEOUT_BIT = 13;
    localparam int STAT_ENABLE_BIT = 14;
    // Enable input timeout in watchdog mode
    localparam longint CLK_HZ = 64'd125000000;
    localparam longint ENABLE_TIMEOUT_MS = 64'd100;
    localparam longint ENABLE_TIMEOUT_CYC = ENABLE_TIMEOUT_MS * CLK_HZ / 64'd1000;
    localparam int TIMER_W = 24;
    typedef enum logic
    {
        TGC_MODE_DIRECT = 1'b0,
        TGC_MODE_WATCHDOG = 1'b1
    } tgc_mode_t;
    typedef enum logic
    {
        TGC_WD_RUN = 1'b0,
        TGC_WD_EXPIRED = 1'b1
    } tgc_wd_state_t;
endpackage

// >>> common/tgc_phase_if.sv
// Signals of one phase between the top and its command decoder
`timescale 1ns/1ps
interface tgc_phase_if;
    logic high_side_input_pin;
    logic low_side_input_pin;
    logic high_side_reg_bit;
    logic low_side_reg_bit;
    logic gates_active;
    logic internal_high_cmd;
    logic internal_low_cmd;
    logic high_gate_out;
    logic low_gate_out;
    modport ctrl
    (
        output high_side_input_pin,
        output low_side_input_pin,
        output high_side_reg_bit,
        output low_side_reg_bit,
        output gates_active,
        input internal_high_cmd,
        input internal_low_cmd,
        input high_gate_out,
        input low_gate_out
    );
    modport phase
    (
        input high_side_input_pin,
        input low_side_input_pin,
        input high_side_reg_bit,
        input low_side_reg_bit,
        input gates_active,
        output internal_high_cmd,
        output internal_low_cmd,
        output high_gate_out,
        output low_gate_out
    );
endinterface

// >>> src/tgc_phase.sv
// Command merge and gate decode for one phase
`timescale 1ns/1ps
module tgc_phase
(
    tgc_phase_if.phase ph
);
    always_comb
    begin
        ph.internal_high_cmd = ph.high_side_input_pin | ph.high_side_reg_bit;
        ph.internal_low_cmd = ph.low_side_input_pin | ph.low_side_reg_bit;
        // Only an exclusive command pair turns on a gate; equal pairs leave the node floating
        ph.high_gate_out = ph.gates_active & ph.internal_high_cmd & ~ph.internal_low_cmd;
        ph.low_gate_out = ph.gates_active & ph.internal_low_cmd & ~ph.internal_high_cmd;
    end
endmodule

// >>> src/tgc_gate_ctrl.sv
// Three-phase gate control logic with Avalon-MM register access
//
// Overview of operation
// - Each phase's internal high command is the OR of its high-side pin and register bit.
// - Each phase's internal low command is the OR of its low-side pin and register bit.
// - With gates active, high-only drives only the high gate, low-only drives only the low gate.
// - When both internal commands of a phase are equal, both of its gates stay off.
// - While gate outputs are disabled, every gate output is held low.
// - Each phase is merged and decoded on its own, isolated from the other phases.
// - An undriven phase input pin reads as logic 0, like a weak pull-down.
// - Direct mode disables gates while enable is low; watchdog mode after the enable timeout.
//
// Added by the designer: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
module tgc_gate_ctrl
#(
    parameter int unsigned ENABLE_TIMEOUT_CYC = int'(tgc_pkg::ENABLE_TIMEOUT_CYC)
)
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic [2:0] high_side_input_pin_i,
    input wire logic [2:0] high_side_pin_driven_i,
    input wire logic [2:0] low_side_input_pin_i,
    input wire logic [2:0] low_side_pin_driven_i,
    input wire logic enable_i,
    output logic [2:0] high_gate_out_o,
    output logic [2:0] low_gate_out_o
);
    localparam int NP = tgc_pkg::NUM_PHASES;

    logic [NP-1:0] high_side_reg_bit;
    logic [NP-1:0] low_side_reg_bit;
    tgc_pkg::tgc_mode_t mode;
    tgc_pkg::tgc_wd_state_t wd_state;
    logic [tgc_pkg::TIMER_W-1:0] wd_timer;
    logic enable_q;
    logic gates_active;
    logic [NP-1:0] int_high;
    logic [NP-1:0] int_low;
    logic [NP-1:0] next_high_gate;
    logic [NP-1:0] next_low_gate;
    logic [NP-1:0] high_pin_eff;
    logic [NP-1:0] low_pin_eff;
    logic wr_take;
    logic rd_take;

    ////////////////////////////////////////////////////////////////////////////////
    // Per-phase decoders
    generate
        for (genvar p = 0; p < NP; p++)
        begin : g_phase
            tgc_phase_if ph_if ();
            // Undriven pins default low
            assign high_pin_eff[p] = high_side_input_pin_i[p] & high_side_pin_driven_i[p];
            assign low_pin_eff[p] = low_side_input_pin_i[p] & low_side_pin_driven_i[p];
            assign ph_if.high_side_input_pin = high_pin_eff[p];
            assign ph_if.low_side_input_pin = low_pin_eff[p];
            assign ph_if.high_side_reg_bit = high_side_reg_bit[p];
            assign ph_if.low_side_reg_bit = low_side_reg_bit[p];
            assign ph_if.gates_active = gates_active;
            assign int_high[p] = ph_if.internal_high_cmd;
            assign int_low[p] = ph_if.internal_low_cmd;
            assign next_high_gate[p] = ph_if.high_gate_out;
            assign next_low_gate[p] = ph_if.low_gate_out;
            // Each phase has its own decoder instance
            tgc_phase u_phase
            (
                .ph(ph_if.phase)
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Gate output registers
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            high_gate_out_o <= '0;
            low_gate_out_o <= '0;
        end
        else
        begin
            high_gate_out_o <= next_high_gate;
            low_gate_out_o <= next_low_gate;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Output enable: direct level or watchdog timeout
    always_comb
    begin
        if (mode == tgc_pkg::TGC_MODE_DIRECT)
        begin
            gates_active = enable_i;
        end
        else
        begin
            gates_active = (wd_state == tgc_pkg::TGC_WD_RUN);
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            enable_q <= 1'b0;
        end
        else
        begin
            enable_q <= enable_i;
        end
    end

    // Any enable edge restarts the timeout; expiry holds until the next edge
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wd_state <= tgc_pkg::TGC_WD_EXPIRED;
            wd_timer <= '0;
        end
        else if (enable_i != enable_q)
        begin
            wd_state <= tgc_pkg::TGC_WD_RUN;
            wd_timer <= '0;
        end
        else
        begin
            case (wd_state)
                tgc_pkg::TGC_WD_RUN:
                begin
                    if (wd_timer >= tgc_pkg::TIMER_W'(ENABLE_TIMEOUT_CYC - 1))
                    begin
                        wd_state <= tgc_pkg::TGC_WD_EXPIRED;
                    end
                    else
                    begin
                        wd_timer <= wd_timer + 1'b1;
                    end
                end
                tgc_pkg::TGC_WD_EXPIRED:
                begin
                    wd_timer <= '0;
                end
                default:
                begin
                    wd_state <= tgc_pkg::TGC_WD_EXPIRED;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Avalon-MM slave: one wait cycle, then the transfer completes
    assign wr_take = avs_write_i & ~avs_waitrequest_o;
    assign rd_take = avs_read_i & avs_waitrequest_o;

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            avs_waitrequest_o <= 1'b1;
        end
        else if ((avs_read_i | avs_write_i) & avs_waitrequest_o)
        begin
            avs_waitrequest_o <= 1'b0;
        end
        else
        begin
            avs_waitrequest_o <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            high_side_reg_bit <= tgc_pkg::CTRL_RESET[tgc_pkg::CTRL_HIGH_LSB +: NP];
            low_side_reg_bit <= tgc_pkg::CTRL_RESET[tgc_pkg::CTRL_LOW_LSB +: NP];
            mode <= tgc_pkg::TGC_MODE_DIRECT;
        end
        else if (wr_take)
        begin
            if (avs_address_i == tgc_pkg::ADDR_CTRL)
            begin
                high_side_reg_bit <= avs_writedata_i[tgc_pkg::CTRL_HIGH_LSB +: NP];
                low_side_reg_bit <= avs_writedata_i[tgc_pkg::CTRL_LOW_LSB +: NP];
            end
            if (avs_address_i == tgc_pkg::ADDR_CONFIG)
            begin
                mode <= tgc_pkg::tgc_mode_t'(avs_writedata_i[tgc_pkg::CFG_MODE_BIT]);
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            avs_readdata_o <= '0;
        end
        else if (rd_take)
        begin
            avs_readdata_o <= '0;
            case (avs_address_i)
                tgc_pkg::ADDR_CTRL:
                begin
                    avs_readdata_o[tgc_pkg::CTRL_HIGH_LSB +: NP] <= high_side_reg_bit;
                    avs_readdata_o[tgc_pkg::CTRL_LOW_LSB +: NP] <= low_side_reg_bit;
                end
                tgc_pkg::ADDR_CONFIG:
                begin
                    avs_readdata_o[tgc_pkg::CFG_MODE_BIT] <= mode;
                end
                tgc_pkg::ADDR_STATUS:
                begin
                    avs_readdata_o[tgc_pkg::STAT_INT_HIGH_LSB +: NP] <= int_high;
                    avs_readdata_o[tgc_pkg::STAT_INT_LOW_LSB +: NP] <= int_low;
                    avs_readdata_o[tgc_pkg::STAT_GATE_HIGH_LSB +: NP] <= high_gate_out_o;
                    avs_readdata_o[tgc_pkg::STAT_GATE_LOW_LSB +: NP] <= low_gate_out_o;
                    avs_readdata_o[tgc_pkg::STAT_ACTIVE_BIT] <= gates_active;
                    avs_readdata_o[tgc_pkg::STAT_TIMEOUT_BIT] <= wd_state;
                    avs_readdata_o[tgc_pkg::STAT_ENABLE_BIT] <= enable_i;
                end
                default:
                begin
                    avs_readdata_o <= '0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_ctrl_write_high_only;
        wr_take && avs_address_i == tgc_pkg::ADDR_CTRL
            && avs_writedata_i[tgc_pkg::CTRL_HIGH_LSB +: NP] == 3'h7
            && avs_writedata_i[tgc_pkg::CTRL_LOW_LSB +: NP] == 3'h0;
    endsequence
    sequence s_quiet_active_pins_low;
        (!(avs_write_i) && high_pin_eff == 3'h0 && low_pin_eff == 3'h0 && gates_active)[*2];
    endsequence

    AST_INT_HIGH_OR: assert property (int_high == (high_pin_eff | high_side_reg_bit))
        else $error("internal high command is not the OR of pin and register");
    AST_INT_LOW_OR: assert property (int_low == (low_pin_eff | low_side_reg_bit))
        else $error("internal low command is not the OR of pin and register");
    AST_REG_DRIVES_HIGH: assert property (s_ctrl_write_high_only
        ##1 s_quiet_active_pins_low |-> high_gate_out_o == 3'h7 && low_gate_out_o == 3'h0)
        else $error("register high-only command did not drive high gates");
    AST_EQUAL_PAIR_OFF: assert property (((high_gate_out_o | low_gate_out_o)
        & ~($past(int_high) ^ $past(int_low))) == 3'h0)
        else $error("gate on with equal command pair");
    AST_DISABLED_LOW: assert property (!gates_active
        |=> high_gate_out_o == 3'h0 && low_gate_out_o == 3'h0)
        else $error("gate output high while outputs disabled");
    AST_PHASE_ISOLATION: assert property (gates_active && int_high[0] && !int_low[0]
        |=> high_gate_out_o[0] && !low_gate_out_o[0])
        else $error("phase 0 output disturbed by other phases");
    AST_UNDRIVEN_PIN_LOW: assert property (high_side_pin_driven_i == 3'h0
        && high_side_reg_bit == 3'h0 |-> int_high == 3'h0)
        else $error("undriven pin read as high");
    AST_DIRECT_ENABLE: assert property (mode == tgc_pkg::TGC_MODE_DIRECT && !enable_i
        |=> high_gate_out_o == 3'h0 && low_gate_out_o == 3'h0)
        else $error("direct mode gates active with enable low");
    AST_WD_EXPIRE: assert property (wd_state == tgc_pkg::TGC_WD_RUN
        && enable_i == enable_q
        && wd_timer == tgc_pkg::TIMER_W'(ENABLE_TIMEOUT_CYC - 1)
        |=> wd_state == tgc_pkg::TGC_WD_EXPIRED)
        else $error("watchdog did not expire at timeout");
    AST_RESET_CLEAR: assert property ($rose(rst_n_i) |-> high_side_reg_bit == 3'h0
        && low_side_reg_bit == 3'h0)
        else $error("register bits not cleared by reset");
endmodule

// >>> bench/tgc_mcu_model.sv
// Controller-side model that drives the phase input pins or lets them float
`timescale 1ns/1ps
module tgc_mcu_model
(
    input wire logic clk_sys_i,
    input wire logic [2:0] high_val_i,
    input wire logic [2:0] low_val_i,
    input wire logic [2:0] drive_i,
    output logic [2:0] high_pin_o,
    output logic [2:0] low_pin_o,
    output logic [2:0] driven_o
);
    logic [2:0] high_last = 3'h0;
    logic [2:0] low_last = 3'h0;

    always_ff @(posedge clk_sys_i)
    begin
        high_last <= high_pin_o;
        low_last <= low_pin_o;
    end

    // Floating pins toggle every cycle, so only the pull-down may decide their level
    assign high_pin_o = (high_val_i & drive_i) | (~high_last & ~drive_i);
    assign low_pin_o = (low_val_i & drive_i) | (~low_last & ~drive_i);
    assign driven_o = drive_i;
endmodule

// >>> bench/tb.sv
// Self-checking bench of the three-phase gate control block
`timescale 1ns/1ps
`define CHK(name, exp, got) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) \
        begin \
            $display("ERROR %s expected %0h seen %0h", name, exp, got); \
            fails++; \
        end \
    end
module tb;
    localparam int TO_CYC = 20;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic enable = 1'b1;
    logic [2:0] high_val = 3'h0;
    logic [2:0] low_val = 3'h0;
    logic [2:0] drive = 3'h7;
    logic [2:0] high_pin;
    logic [2:0] low_pin;
    logic [2:0] driven;
    logic [2:0] high_gate;
    logic [2:0] low_gate;
    logic [31:0] seed = 32'h0000_7F23;
    logic [31:0] rd;
    int fails = 0;
    int total_checks = 0;
    int cycles = 0;

    always #4 clk_sys_i = ~clk_sys_i;

    tgc_gate_ctrl #(.ENABLE_TIMEOUT_CYC(TO_CYC)) dut
    (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .avs_address_i(avs_address),
        .avs_read_i(avs_read),
        .avs_write_i(avs_write),
        .avs_writedata_i(avs_writedata),
        .avs_readdata_o(avs_readdata),
        .avs_waitrequest_o(avs_waitrequest),
        .high_side_input_pin_i(high_pin),
        .high_side_pin_driven_i(driven),
        .low_side_input_pin_i(low_pin),
        .low_side_pin_driven_i(driven),
        .enable_i(enable),
        .high_gate_out_o(high_gate),
        .low_gate_out_o(low_gate)
    );

    tgc_mcu_model mcu
    (
        .clk_sys_i(clk_sys_i),
        .high_val_i(high_val),
        .low_val_i(low_val),
        .drive_i(drive),
        .high_pin_o(high_pin),
        .low_pin_o(low_pin),
        .driven_o(driven)
    );

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [5:0] exp_gates(input logic [2:0] h, input logic [2:0] l,
                                             input logic en);
        return en ? {l & ~h, h & ~l} : 6'h00;
    endfunction

    // One Avalon-MM transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] addr, input logic [31:0] wdata);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        avs_address <= addr;
        avs_writedata <= wdata;
        avs_write <= wr;
        avs_read <= ~wr;
        @(posedge clk_sys_i);
        while (avs_waitrequest !== 1'b0 && n < 50)
        begin
            @(posedge clk_sys_i);
            n++;
        end
        if (n == 50)
        begin
            fails++;
            end_of_test();
        end
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic settle();
        repeat (3) @(posedge clk_sys_i);
        #1;
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge clk_sys_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fails++;
            end_of_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        logic [31:0] r;
        logic [2:0] eh;
        logic [2:0] el;
        logic [5:0] regs;
        logic [31:0] corner [4];
        corner[0] = 32'h0003_1007;
        corner[1] = 32'h0002_1FC0;
        corner[2] = 32'h0002_11F8;
        corner[3] = 32'h0002_11C7;
        repeat (16) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        bus(1'b0, tgc_pkg::ADDR_CTRL, 32'h0000_0000);
        `CHK("ctrl reset", 6'h00, rd[5:0])
        bus(1'b0, 4'hC, 32'h0000_0000);
        `CHK("unmapped read", 32'h0000_0000, rd)
        `CHK("gates after reset", 6'h00, {low_gate, high_gate})
        $display("test reset done");
        // Corners: register only, both pins high, pin against register, pin with register
        // Random draws then use one source only
        for (int i = 0; i < 60; i++)
        begin
            seed = lfsr(seed);
            r = (i < 4) ? corner[i] : seed;
            regs = (i < 4 || r[16]) ? r[5:0] : 6'h00;
            bus(1'b1, tgc_pkg::ADDR_CTRL, {26'h0, regs});
            bus(1'b0, tgc_pkg::ADDR_CTRL, 32'h0000_0000);
            `CHK("ctrl readback", regs, rd[5:0])
            high_val <= r[16] ? 3'h0 : r[8:6];
            low_val <= r[16] ? 3'h0 : r[11:9];
            drive <= r[12] ? 3'h7 : r[15:13];
            enable <= r[17] | r[18];
            settle();
            eh = regs[2:0] | (high_val & drive);
            el = regs[5:3] | (low_val & drive);
            `CHK("gates", exp_gates(eh, el, enable), {low_gate, high_gate})
            bus(1'b0, tgc_pkg::ADDR_STATUS, 32'h0000_0000);
            `CHK("internal cmds", {el, eh}, rd[5:0])
            `CHK("status gates", exp_gates(eh, el, enable), rd[11:6])
            `CHK("status enable", {enable, enable}, {rd[14], rd[12]})
        end
        $display("test merge and decode done");
        high_val <= 3'h7;
        low_val <= 3'h0;
        drive <= 3'h7;
        bus(1'b1, tgc_pkg::ADDR_CTRL, 32'h0000_0000);
        bus(1'b1, tgc_pkg::ADDR_CONFIG, 32'h0000_0001);
        bus(1'b0, tgc_pkg::ADDR_CONFIG, 32'h0000_0000);
        `CHK("config readback", 1'b1, rd[0])
        repeat (TO_CYC + 5) @(posedge clk_sys_i);
        #1;
        `CHK("watchdog idle", 6'h00, {low_gate, high_gate})
        @(posedge clk_sys_i);
        enable <= ~enable;
        settle();
        `CHK("watchdog running", 6'h07, {low_gate, high_gate})
        // Last cycle before expiry, then the first cycle after it
        repeat (TO_CYC - 2) @(posedge clk_sys_i);
        #1;
        `CHK("watchdog before limit", 6'h07, {low_gate, high_gate})
        @(posedge clk_sys_i);
        #1;
        `CHK("watchdog timeout", 6'h00, {low_gate, high_gate})
        bus(1'b0, tgc_pkg::ADDR_STATUS, 32'h0000_0000);
        `CHK("status expired", 2'h2, rd[13:12])
        @(posedge clk_sys_i);
        enable <= ~enable;
        settle();
        `CHK("watchdog restart", 6'h07, {low_gate, high_gate})
        $display("test watchdog done");
        // Reset in mid-run must clear register bits that were set
        bus(1'b1, tgc_pkg::ADDR_CTRL, 32'h0000_003F);
        bus(1'b0, tgc_pkg::ADDR_CTRL, 32'h0000_0000);
        `CHK("ctrl before reset", 6'h3F, rd[5:0])
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        bus(1'b0, tgc_pkg::ADDR_CTRL, 32'h0000_0000);
        `CHK("ctrl after reset", 6'h00, rd[5:0])
        bus(1'b0, tgc_pkg::ADDR_CONFIG, 32'h0000_0000);
        `CHK("mode after reset", 1'b0, rd[0])
        $display("test mid-run reset done");
        end_of_test();
    end
endmodule
